// file: hw/gpp_pkg.sv
package gpp_pkg;

  localparam int unsigned ADR_W        = 8;
  localparam int unsigned DAT_W        = 32;
  localparam int unsigned PORT_W_DFLT  = 8;
  localparam int unsigned PORT_W_MAX   = 8;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] OFS_DIRECTION   = 8'h04;
  localparam logic [7:0] OFS_PIN_INPUT   = 8'h08;
  localparam logic [7:0] OFS_MCU_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_DIR_SET     = 8'h10;
  localparam logic [7:0] OFS_DIR_CLEAR   = 8'h14;
  localparam logic [7:0] OFS_DATA_SET    = 8'h18;
  localparam logic [7:0] OFS_DATA_CLEAR  = 8'h1C;

  // Control register fields.
  localparam int unsigned PULLUP_DIS_BIT = 0;

  // Reset values.
  localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION   = 8'h00;
  localparam logic       RST_PULLUP_DIS  = 1'b0;

  // Bus answer latency in cycles after the request is first seen.
  localparam int unsigned ACK_LATENCY = 1;

endpackage

// file: hw/gpp_port.sv
`timescale 1ns/1ns
// What this block does
// - Output data, direction, read-only pin input registers.
// - Writing one to pin input toggles data.
// - Global pull-up disable kills every pull-up.
// - Direction one drives pin, zero releases.
// - Pull-up only when input, data one, enabled.
// - Reset tri-states all pins asynchronously.
// - Output pin follows its data bit.
// - Pin input shows synchronized pin level unless sleep clamps it low.
// - Latch open on clock high, then flop.
// - External change seen after half to 1.5 cycles.
// - Own driven value returns after one cycle.
// - Set and clear change only addressed bits.
// - Alternate function leaves other pins as GPIO.
// - Sleep clamps input low unless interrupt-exempt.
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PORT_W = gpp_pkg::PORT_W_DFLT
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      ARST_N,
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [gpp_pkg::ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [gpp_pkg::DAT_W-1:0] WB_DAT_I,
  output logic      [gpp_pkg::DAT_W-1:0] WB_DAT_O,
  output logic                           WB_ACK_O,
  input  wire logic [PORT_W-1:0]         PAD_IN,
  output logic      [PORT_W-1:0]         PAD_OUT,
  output logic      [PORT_W-1:0]         PAD_OE,
  output logic      [PORT_W-1:0]         PAD_PULLUP,
  input  wire logic [PORT_W-1:0]         ALT_EN,
  input  wire logic [PORT_W-1:0]         ALT_OE,
  input  wire logic [PORT_W-1:0]         ALT_OUT,
  input  wire logic                      SLEEP_CLAMP,
  input  wire logic [PORT_W-1:0]         EXT_INT_EXEMPT
);
  import gpp_pkg::*;

  if (PORT_W < 1 || PORT_W > PORT_W_MAX) begin : g_bad_width
    $error("PORT_W must lie between 1 and 8.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic              ack_reg;
  logic              ack_next;
  logic [DAT_W-1:0]  rdata_reg;
  logic [DAT_W-1:0]  rdata_next;
  logic [PORT_W-1:0] output_data_reg;
  logic [PORT_W-1:0] output_data_next;
  logic [PORT_W-1:0] direction_reg;
  logic [PORT_W-1:0] direction_next;
  logic              pullup_dis_reg;
  logic              pullup_dis_next;
  logic [PORT_W-1:0] pin_input_reg;
  logic [PORT_W-1:0] sync_latch;
  logic [PORT_W-1:0] pad_out_next;
  logic [PORT_W-1:0] pad_oe_next;
  logic [PORT_W-1:0] pad_pullup_next;

  wire              bus_req   = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where the master samples ack, never earlier.
  wire              wr_fire   = bus_req & WB_WE_I & ack_reg & WB_SEL_I[0];
  wire [PORT_W-1:0] wr_bits   = WB_DAT_I[PORT_W-1:0];
  wire              hit_data  = (WB_ADR_I == OFS_OUTPUT_DATA);
  wire              hit_dir   = (WB_ADR_I == OFS_DIRECTION);
  wire              hit_pin   = (WB_ADR_I == OFS_PIN_INPUT);
  wire              hit_ctrl  = (WB_ADR_I == OFS_MCU_CONTROL);
  wire              hit_dset  = (WB_ADR_I == OFS_DIR_SET);
  wire              hit_dclr  = (WB_ADR_I == OFS_DIR_CLEAR);
  wire              hit_oset  = (WB_ADR_I == OFS_DATA_SET);
  wire              hit_oclr  = (WB_ADR_I == OFS_DATA_CLEAR);
  wire              hit_any   = hit_data | hit_dir | hit_pin | hit_ctrl
                                | hit_dset | hit_dclr | hit_oset | hit_oclr;
  wire              wr_data   = wr_fire & hit_data;
  wire              wr_dir    = wr_fire & hit_dir;
  wire              wr_pin    = wr_fire & hit_pin;
  wire              wr_ctrl   = wr_fire & hit_ctrl;
  wire              wr_dset   = wr_fire & hit_dset;
  wire              wr_dclr   = wr_fire & hit_dclr;
  wire              wr_oset   = wr_fire & hit_oset;
  wire              wr_oclr   = wr_fire & hit_oclr;

  wire [DAT_W-1:0] rd_data = {{(DAT_W-PORT_W){1'b0}}, output_data_reg};
  wire [DAT_W-1:0] rd_dir  = {{(DAT_W-PORT_W){1'b0}}, direction_reg};
  wire [DAT_W-1:0] rd_pin  = {{(DAT_W-PORT_W){1'b0}}, pin_input_reg};
  wire [DAT_W-1:0] rd_ctrl = {{(DAT_W-1){1'b0}}, pullup_dis_reg};

  // Set and clear aliases read back the register they act on.
  assign rdata_next = (hit_data | hit_oset | hit_oclr) ? rd_data :
                      (hit_dir | hit_dset | hit_dclr)  ? rd_dir  :
                      hit_pin                          ? rd_pin  :
                      hit_ctrl                         ? rd_ctrl :
                      '0;
  assign ack_next = bus_req & ~ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  // Toggle, set and clear touch only the bits written as one.
  assign output_data_next = wr_data ? wr_bits :
                            wr_pin  ? (output_data_reg ^ wr_bits) :
                            wr_oset ? (output_data_reg | wr_bits) :
                            wr_oclr ? (output_data_reg & ~wr_bits) :
                            output_data_reg;
  assign direction_next   = wr_dir  ? wr_bits :
                            wr_dset ? (direction_reg | wr_bits) :
                            wr_dclr ? (direction_reg & ~wr_bits) :
                            direction_reg;
  assign pullup_dis_next  = wr_ctrl ? WB_DAT_I[PULLUP_DIS_BIT] : pullup_dis_reg;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_reg         <= 1'b0;
      rdata_reg       <= '0;
      output_data_reg <= RST_OUTPUT_DATA[PORT_W-1:0];
      direction_reg   <= RST_DIRECTION[PORT_W-1:0];
      pullup_dis_reg  <= RST_PULLUP_DIS;
    end else begin
      ack_reg         <= ack_next;
      rdata_reg       <= rdata_next;
      output_data_reg <= output_data_next;
      direction_reg   <= direction_next;
      pullup_dis_reg  <= pullup_dis_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pad control, one slice per pin.

  // An alternate function takes over only its own pin, so the rest of the
  // port keeps plain digital behaviour.
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    assign pad_oe_next[i]     = ALT_EN[i] ? ALT_OE[i] : direction_reg[i];
    assign pad_out_next[i]    = ALT_EN[i] ? ALT_OUT[i] : output_data_reg[i];
    assign pad_pullup_next[i] = ~ALT_EN[i] & ~direction_reg[i]
                                & output_data_reg[i] & ~pullup_dis_reg;
  end

  // The pads are registered so that reset releases them with no clock.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PAD_OE     <= '0;
      PAD_OUT    <= '0;
      PAD_PULLUP <= '0;
    end else begin
      PAD_OE     <= pad_oe_next;
      PAD_OUT    <= pad_out_next;
      PAD_PULLUP <= pad_pullup_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronizer.

  // Sleeping inputs not marked in EXT_INT_EXEMPT are forced low so a floating pad draws no current.
  wire [PORT_W-1:0] din_clamped = PAD_IN & ~({PORT_W{SLEEP_CLAMP}} & ~EXT_INT_EXEMPT);

  // The latch halves the synchronizer delay; it is read by the flop only.
  always_latch begin
    if (CLK_SYS) begin
      sync_latch = din_clamped;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_input_reg <= '0;
    end else begin
      pin_input_reg <= sync_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_bus_write(logic [ADR_W-1:0] ofs);
    bus_req & WB_WE_I & WB_SEL_I[0] & ack_reg & (WB_ADR_I == ofs);
  endsequence

  sequence s_one_cycle_loop;
    ##1 1'b1;
  endsequence

  a_reset_tri_state: assert property (
    @(posedge CLK_SYS) !ARST_N |-> (PAD_OE == '0) && (PAD_PULLUP == '0))
    else $error("Pins not released during reset.");

  a_toggle_write: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_PIN_INPUT) |=>
      output_data_reg == ($past(output_data_reg) ^ $past(wr_bits)))
    else $error("Pin input write did not toggle data bits.");

  a_set_only_bits: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_DIR_SET) |=>
      (direction_reg & ~$past(wr_bits)) == ($past(direction_reg) & ~$past(wr_bits))
      && ((direction_reg & $past(wr_bits)) == $past(wr_bits)))
    else $error("Direction set disturbed other bits.");

  a_clear_only_bits: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_DATA_CLEAR) |=>
      output_data_reg == ($past(output_data_reg) & ~$past(wr_bits)))
    else $error("Data clear disturbed other bits.");

  a_pullup_rule: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_one_cycle_loop |-> PAD_PULLUP ==
      ($past(~ALT_EN & ~direction_reg & output_data_reg) & {PORT_W{~$past(pullup_dis_reg)}}))
    else $error("Pull-up enable does not match direction, data and disable.");

  a_driver_follows: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ($past(ALT_EN) == '0) && $past(ARST_N) |->
      (PAD_OE == $past(direction_reg)) && (PAD_OUT == $past(output_data_reg)))
    else $error("Pad driver does not follow direction and data.");

  a_pin_sync_delay: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    $past(ARST_N) |-> pin_input_reg == $past(din_clamped))
    else $error("Pin input register lags the pin by other than one edge.");

  a_sleep_clamp: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    $past(SLEEP_CLAMP) && $past(ARST_N) |->
      (pin_input_reg & ~$past(EXT_INT_EXEMPT)) == '0)
    else $error("Sleeping input not clamped low.");

  a_ack_single: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    bus_req && !ack_reg |=> ack_reg ##1 !ack_reg)
    else $error("Bus ack not a single cycle one edge after request.");

  a_reset_values: assert property (
    @(posedge CLK_SYS) $rose(ARST_N) |->
      (direction_reg == '0) && (output_data_reg == '0) && (PAD_PULLUP == '0))
    else $error("Port registers not zero after reset.");

  // A read is taken on the edge that sees the request with ack still low.
  sequence s_bus_read_start;
    bus_req & !WB_WE_I & !ack_reg;
  endsequence

  a_data_write_lands: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_OUTPUT_DATA) |=> output_data_reg == $past(wr_bits))
    else $error("Output data write did not land.");

  a_dir_write_lands: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_DIRECTION) |=> direction_reg == $past(wr_bits))
    else $error("Direction write did not land.");

  // The pin input location only toggles data; nothing else may move.
  a_pin_read_only: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_PIN_INPUT) |=> $stable(direction_reg) && $stable(pullup_dis_reg))
    else $error("Pin input write changed a register other than data.");

  a_ctrl_write_lands: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_MCU_CONTROL) |=> pullup_dis_reg == $past(WB_DAT_I[PULLUP_DIS_BIT]))
    else $error("Control write did not land.");

  a_dir_clear_bits: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_DIR_CLEAR) |=> direction_reg == ($past(direction_reg) & ~$past(wr_bits)))
    else $error("Direction clear disturbed other bits.");

  a_data_set_bits: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_write(OFS_DATA_SET) |=> output_data_reg == ($past(output_data_reg) | $past(wr_bits)))
    else $error("Data set disturbed other bits.");

  // Unmapped offsets are answered so the master never hangs, but ignored.
  a_unmapped_ignored: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    bus_req & WB_WE_I & ack_reg & ~hit_any |=>
      $stable(output_data_reg) && $stable(direction_reg) && $stable(pullup_dis_reg))
    else $error("Write to an unmapped offset changed a register.");

  a_sel_gates_write: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    bus_req & WB_WE_I & ack_reg & ~WB_SEL_I[0] |=>
      $stable(output_data_reg) && $stable(direction_reg) && $stable(pullup_dis_reg))
    else $error("Write without byte select changed a register.");

  a_read_upper_zero: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ack_reg |-> (WB_DAT_O >> PORT_W) == '0)
    else $error("Read data above the port width is not zero.");

  a_read_pin_value: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_bus_read_start ##0 hit_pin |=> WB_DAT_O == $past(rd_pin))
    else $error("Pin input read does not return the synchronized level.");

  a_pullup_global_off: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    $past(pullup_dis_reg) && $past(ARST_N) |-> PAD_PULLUP == '0)
    else $error("Pull-up active while globally disabled.");

  // A driven pin with its pull-up on would fight the driver for nothing.
  a_no_pullup_drive: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (PAD_PULLUP & PAD_OE) == '0)
    else $error("Pull-up enabled on a driven pin.");

  a_alt_pullup_off: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    $past(ARST_N) |-> (PAD_PULLUP & $past(ALT_EN)) == '0)
    else $error("Pull-up active on a pin owned by an alternate function.");

  a_alt_takes_pin: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    $past(ARST_N) |-> ((PAD_OE ^ $past(ALT_OE)) & $past(ALT_EN)) == '0)
    else $error("Alternate function does not own its driver enable.");

  a_reset_out_low: assert property (
    @(posedge CLK_SYS) !ARST_N |-> PAD_OUT == '0)
    else $error("Pad drive value not cleared during reset.");

  a_ack_needs_req: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ack_reg |-> $past(bus_req))
    else $error("Bus ack without a request.");

  a_ack_no_double: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ack_reg |=> !ack_reg)
    else $error("Bus ack held for more than one cycle.");

endmodule

// file: tb/gpp_pad_model.sv
`timescale 1ns/1ns
module gpp_pad_model #(
  parameter int unsigned PORT_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic [PORT_W-1:0] pad_out,
  input  wire logic [PORT_W-1:0] pad_oe,
  input  wire logic [PORT_W-1:0] pad_pullup,
  input  wire logic [PORT_W-1:0] ext_en,
  input  wire logic [PORT_W-1:0] ext_val,
  output logic      [PORT_W-1:0] pad_in
);
  // A floating pin flips every cycle so a stale value never passes as a read.
  logic [PORT_W-1:0] flt_reg = '0;
  always_ff @(posedge clk_sys) begin
    flt_reg <= ~flt_reg;
  end
  // Our driver wins, then the board, then the pull-up.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | flt_reg));
endmodule

// file: tb/tb_general_purpose_io_port.sv
`timescale 1ns/1ns
module tb_general_purpose_io_port;
  import gpp_pkg::*;
  logic        clk = 0, arst_n, cyc = 0, stb = 0, we = 0, clamp = 0;
  logic [3:0]  sel = 4'h0, sel_val = 4'h1;
  logic [7:0]  adr = '0, ext_en = '0, ext_val = '0, exempt = '0;
  logic [7:0]  alt_en = '0, alt_oe = '0, alt_out = '0;
  logic [31:0] wdat = '0, rd;
  wire  [31:0] dat_o;
  wire         ack;
  wire  [7:0]  p_out, p_oe, p_pu, p_in;
  int          fails = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  gpp_port #(.PORT_W(8)) DUT (.CLK_SYS(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PAD_IN(p_in), .PAD_OUT(p_out), .PAD_OE(p_oe),
    .PAD_PULLUP(p_pu), .ALT_EN(alt_en), .ALT_OE(alt_oe), .ALT_OUT(alt_out),
    .SLEEP_CLAMP(clamp), .EXT_INT_EXEMPT(exempt));
  gpp_pad_model #(.PORT_W(8)) board (.clk_sys(clk), .pad_out(p_out), .pad_oe(p_oe),
    .pad_pullup(p_pu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(p_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The slave answer time is not assumed; the wait ends on ack or after 20 cycles.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_val;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    chk({31'h0, ack}, 32'h1);
    if (ack !== 1'b1) give_verdict;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pads(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
    @(posedge clk);
    #1;
    chk({24'h0, p_oe}, {24'h0, oe});
    chk({24'h0, p_out & oe}, {24'h0, out & oe});
    chk({24'h0, p_pu}, {24'h0, pu});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(OFS_OUTPUT_DATA, 32'h0);
    rdchk(OFS_DIRECTION, 32'h0);
    pads(8'h00, 8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_config;
    @(posedge clk);
    ext_en <= 8'h30;
    ext_val <= 8'h00;
    // Tri-state to output high passes through the pull-up state.
    wb(1'b1, OFS_OUTPUT_DATA, 32'hC3);
    pads(8'h00, 8'h00, 8'hC3);
    wb(1'b1, OFS_DIRECTION, 32'h0F);
    pads(8'h0F, 8'h03, 8'hC0);
    rdchk(OFS_OUTPUT_DATA, 32'hC3);
    rdchk(OFS_PIN_INPUT, 32'hC3);
    $display("test config done");
  endtask
  task automatic t_pud;
    wb(1'b1, OFS_MCU_CONTROL, 32'h1);
    pads(8'h0F, 8'h03, 8'h00);
    rdchk(OFS_MCU_CONTROL, 32'h1);
    wb(1'b1, 8'h24, 32'hFF);
    rdchk(8'h24, 32'h0);
    // A write with byte lane 0 unselected must be ignored.
    sel_val = 4'h0;
    wb(1'b1, OFS_DIRECTION, 32'hFF);
    sel_val = 4'h1;
    rdchk(OFS_DIRECTION, 32'h0F);
    wb(1'b1, OFS_MCU_CONTROL, 32'h0);
    pads(8'h0F, 8'h03, 8'hC0);
    $display("test pull-up disable done");
  endtask
  task automatic t_toggle;
    wb(1'b1, OFS_PIN_INPUT, 32'h81);
    pads(8'h0F, 8'h02, 8'h40);
    rdchk(OFS_OUTPUT_DATA, 32'h42);
    $display("test toggle done");
  endtask
  task automatic t_setclr;
    wb(1'b1, OFS_DIR_SET, 32'h80);
    wb(1'b1, OFS_DIR_CLEAR, 32'h01);
    wb(1'b1, OFS_DATA_SET, 32'h20);
    wb(1'b1, OFS_DATA_CLEAR, 32'h02);
    pads(8'h8E, 8'h60, 8'h60);
    // Pull-up to output low goes through tri-state on pin 6.
    wb(1'b1, OFS_DATA_CLEAR, 32'h40);
    wb(1'b1, OFS_DIR_SET, 32'h40);
    pads(8'hCE, 8'h20, 8'h20);
    rdchk(OFS_DIRECTION, 32'hCE);
    $display("test set clear done");
  endtask
  task automatic t_alt;
    @(posedge clk);
    alt_en <= 8'h80;
    alt_oe <= 8'h80;
    alt_out <= 8'h80;
    pads(8'hCE, 8'hA0, 8'h20);
    @(posedge clk);
    alt_en <= 8'h00;
    $display("test alternate done");
  endtask
  task automatic t_sleep;
    wb(1'b1, OFS_DIRECTION, 32'h0);
    @(posedge clk);
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    clamp <= 1'b1;
    exempt <= 8'h01;
    rdchk(OFS_PIN_INPUT, 32'h01);
    @(posedge clk);
    clamp <= 1'b0;
    rdchk(OFS_PIN_INPUT, 32'hFF);
    $display("test sleep done");
  endtask
  task automatic t_areset;
    wb(1'b1, OFS_DIRECTION, 32'hFF);
    pads(8'hFF, 8'h20, 8'h00);
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    chk({24'h0, p_oe | p_pu}, 32'h0);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(OFS_DIRECTION, 32'h0);
    $display("test async reset done");
  endtask
  initial begin
    // Driven from unknown at time zero so the asynchronous reset sees an edge.
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_config;
    t_pud;
    t_toggle;
    t_setclr;
    t_alt;
    t_sleep;
    t_areset;
    give_verdict;
  end
endmodule
